// file: core/pcard_pkg.sv
package pcard_pkg;

  // Register indices; the byte address of a register is four times its index.
  localparam logic [5:0] IDX_IDENT      = 6'h00;
  localparam logic [5:0] IDX_IRQ_DMA    = 6'h01;
  localparam logic [5:0] IDX_LINE_CTL   = 6'h02;
  localparam logic [5:0] IDX_DATA       = 6'h03;
  localparam logic [5:0] IDX_READY      = 6'h04;
  localparam logic [5:0] IDX_LINE_STATE = 6'h05;
  localparam logic [5:0] IDX_EVT_STATUS = 6'h08;
  localparam logic [5:0] IDX_EVT_MASK   = 6'h09;
  localparam logic [5:0] IDX_IRQ_DMA_EN = 6'h0a;

  localparam int IDX_LSB = 2;

  // Bit positions.
  localparam int BIT_CTL_A    = 0;
  localparam int BIT_CTL_B    = 1;
  localparam int BIT_IRQ_EN   = 7;
  localparam int BIT_IRQ_PEND = 6;
  localparam int BIT_PRIO_LO  = 4;
  localparam int BIT_PERIPHERAL_OK_INPUT_OK  = 3;
  localparam int BIT_EIR_LOW  = 2;
  localparam int BIT_STI_B    = 1;
  localparam int BIT_STI_A    = 0;

  // Writable bits of the interrupt and DMA enable register.
  localparam logic [7:0] IRQ_DMA_EN_MASK = 8'h8f;
  localparam logic [7:0] CTL_RESET       = 8'h00;
  localparam logic [15:0] DOUT_RESET     = 16'h0000;

  // Event bits of the sticky event status register.
  localparam int EVT_READY = 0;
  localparam int EVT_EIR   = 1;
  localparam int EVT_STI_A = 2;
  localparam int EVT_STI_B = 3;
  localparam int N_EVT     = 4;

  localparam logic [1:0] RESP_OKAY   = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;

  // Peripheral-side input lines, all asynchronous to aclk.
  typedef struct packed {
    logic status_in_a;
    logic status_in_b;
    logic peripheral_ok_input;
    logic external_irq_input;
    logic peripheral_flag_in;
  } line_in_t;

endpackage

// file: core/parallel_card_status_control_bank.sv
// The AXI4-Lite slave port was chosen for this implementation.
`timescale 1ns/10ps
// Functional notes
// - Writing one to control bit 0 or 1 drives line a or b low.
// - Writing zero to a control bit drives its line high, fixed polarity.
// - Control lines hold their level until the control register is rewritten.
// - Interface reset leaves control lines and their register bits unchanged.
// - Status lines a and b appear in bits 0 and 1 of line state.
// - A status bit reads one when its line is low, fixed inversion.
// - Line state reads return live levels; nothing latches them.
// - Line state bits 7..4 read zero; bit 3 peripheral OK; bit 2 irq line low.
// - Non-zero write to index 0 resets the interface; zero does nothing.
// - Non-zero write to index 1 sets the handshake request line.
// - Index 1 reads irq enable, pending, priority, DMA mode and channel enables.
// - Index 3 read returns all sixteen input data lines as one word.
// - Writing index 3 drives the strobed bytes of the sixteen-bit word onto the output lines.
// - Index 4 reads one when ready and zero while busy.
// - Data word write changes only data lines and direction; no handshake.
// - Data word read drives direction high unless a data write fires in the same cycle, and samples input; no handshake.
module parallel_card_status_control_bank
  import pcard_pkg::*;
#(
  parameter int         ADDR_W  = 8,
  parameter logic [7:0] CARD_ID = 8'h5a  // Arbitrary identity value.
) (
  input  wire logic              aclk,
  input  wire logic              aresetn,
  input  wire logic [ADDR_W-1:0] awaddr,
  input  wire logic [2:0]        awprot,
  input  wire logic              awvalid,
  output      logic              awready,
  input  wire logic [31:0]       wdata,
  input  wire logic [3:0]        wstrb,
  input  wire logic              wvalid,
  output      logic              wready,
  output      logic [1:0]        bresp,
  output      logic              bvalid,
  input  wire logic              bready,
  input  wire logic [ADDR_W-1:0] araddr,
  input  wire logic [2:0]        arprot,
  input  wire logic              arvalid,
  output      logic              arready,
  output      logic [31:0]       rdata,
  output      logic [1:0]        rresp,
  output      logic              rvalid,
  input  wire logic              rready,
  input  wire line_in_t          line_in,
  input  wire logic [15:0]       input_data_lines,
  input  wire logic [1:0]        priority_switch,
  output      logic              control_out_a,
  output      logic              control_out_b,
  output      logic              handshake_request_out,
  output      logic              io_direction_out,
  output      logic [15:0]       output_data_lines,
  output      logic              irq
);

  if (ADDR_W < 6 || ADDR_W > 32) begin : g_bad_addr_w
    $error("ADDR_W must lie between 6 and 32");
  end

  localparam int SYNC_W = $bits(line_in_t) + 16 + 2;

  // Two-stage synchroniser for every pin input.
  logic [SYNC_W-1:0] sync1_r;
  logic [SYNC_W-1:0] sync2_r;
  line_in_t          line_s;
  logic [15:0]       din_s;
  logic [1:0]        prio_s;
  line_in_t          line_prev_r;
  logic [2:0]        warm_r;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sync1_r <= '0;
      sync2_r <= '0;
    end else begin
      sync1_r <= {line_in, input_data_lines, priority_switch};
      sync2_r <= sync1_r;
    end
  end

  assign {line_s, din_s, prio_s} = sync2_r;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      line_prev_r <= '0;
      warm_r      <= '0;
    end else begin
      line_prev_r <= line_s;
      warm_r      <= {warm_r[1:0], 1'b1};
    end
  end

  // AXI4-Lite write path: address and data are taken independently.
  logic              aw_hold_r;
  logic              w_hold_r;
  logic [5:0]        aw_idx_r;
  logic [31:0]       w_data_r;
  logic [3:0]        w_strb_r;
  logic              bvalid_r;
  logic [1:0]        bresp_r;
  logic              wr_fire;
  logic              wr_mapped;
  logic              lane0;

  assign awready   = !aw_hold_r && !bvalid_r;
  assign wready    = !w_hold_r && !bvalid_r;
  assign wr_fire   = aw_hold_r && w_hold_r && !bvalid_r;
  assign lane0     = w_strb_r[0];
  assign bvalid    = bvalid_r;
  assign bresp     = bresp_r;

  always_comb begin
    unique case (aw_idx_r)
      IDX_IDENT, IDX_IRQ_DMA, IDX_LINE_CTL, IDX_DATA,
      IDX_EVT_STATUS, IDX_EVT_MASK, IDX_IRQ_DMA_EN: wr_mapped = 1'b1;
      default:                                       wr_mapped = 1'b0;
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_hold_r <= 1'b0;
      aw_idx_r  <= '0;
    end else if (awvalid && awready) begin
      aw_hold_r <= 1'b1;
      aw_idx_r  <= awaddr[IDX_LSB +: 6];
    end else if (wr_fire) begin
      aw_hold_r <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      w_hold_r <= 1'b0;
      w_data_r <= '0;
      w_strb_r <= '0;
    end else if (wvalid && wready) begin
      w_hold_r <= 1'b1;
      w_data_r <= wdata;
      w_strb_r <= wstrb;
    end else if (wr_fire) begin
      w_hold_r <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bvalid_r <= 1'b0;
      bresp_r  <= RESP_OKAY;
    end else if (wr_fire) begin
      bvalid_r <= 1'b1;
      bresp_r  <= wr_mapped ? RESP_OKAY : RESP_SLVERR;
    end else if (bready) begin
      bvalid_r <= 1'b0;
    end
  end

  // Write strobes per register.
  logic wr_reset;
  logic wr_hs;
  logic wr_ctl;
  logic wr_data;
  logic wr_evt;
  logic wr_mask;
  logic wr_en;

  assign wr_reset = wr_fire && aw_idx_r == IDX_IDENT && lane0 && w_data_r[7:0] != 8'h00;
  assign wr_hs    = wr_fire && aw_idx_r == IDX_IRQ_DMA && lane0 && w_data_r[7:0] != 8'h00;
  assign wr_ctl   = wr_fire && aw_idx_r == IDX_LINE_CTL && lane0;
  assign wr_data  = wr_fire && aw_idx_r == IDX_DATA && (w_strb_r[1:0] != 2'b00);
  assign wr_evt   = wr_fire && aw_idx_r == IDX_EVT_STATUS && lane0;
  assign wr_mask  = wr_fire && aw_idx_r == IDX_EVT_MASK && lane0;
  assign wr_en    = wr_fire && aw_idx_r == IDX_IRQ_DMA_EN && lane0;

  // Control line register; the interface reset deliberately does not touch it.
  logic [1:0] ctl_r;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctl_r <= CTL_RESET[1:0];
    end else if (wr_ctl) begin
      ctl_r <= w_data_r[BIT_CTL_B:BIT_CTL_A];
    end
  end

  assign control_out_a = !ctl_r[BIT_CTL_A];
  assign control_out_b = !ctl_r[BIT_CTL_B];

  // Output data word and direction line.
  logic [15:0] dout_r;
  logic        io_dir_r;
  logic        rd_fire;
  logic [5:0]  rd_idx;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      dout_r <= DOUT_RESET;
    end else if (wr_data) begin
      if (w_strb_r[0]) begin
        dout_r[7:0] <= w_data_r[7:0];
      end
      if (w_strb_r[1]) begin
        dout_r[15:8] <= w_data_r[15:8];
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      io_dir_r <= 1'b1;
    end else if (wr_data) begin
      io_dir_r <= 1'b0;
    end else if (rd_fire && rd_idx == IDX_DATA) begin
      io_dir_r <= 1'b1;
    end
  end

  assign output_data_lines = dout_r;
  assign io_direction_out  = io_dir_r;

  // Handshake request: set by software, cleared by the peripheral flag or reset.
  logic hs_r;
  logic flag_rise;

  assign flag_rise = line_s.peripheral_flag_in && !line_prev_r.peripheral_flag_in;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      hs_r <= 1'b0;
    end else if (wr_hs) begin
      hs_r <= 1'b1;
    end else if (wr_reset || flag_rise) begin
      hs_r <= 1'b0;
    end
  end

  assign handshake_request_out = hs_r;

  // Interrupt and DMA enables.
  logic [7:0] irq_dma_en_r;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      irq_dma_en_r <= 8'h00;
    end else if (wr_reset) begin
      irq_dma_en_r <= 8'h00;
    end else if (wr_en) begin
      irq_dma_en_r <= w_data_r[7:0] & IRQ_DMA_EN_MASK;
    end
  end

  // Sticky events; a new event wins over a write-one-to-clear.
  logic [N_EVT-1:0] evt_r;
  logic [N_EVT-1:0] evt_nxt;
  logic [N_EVT-1:0] mask_r;
  logic [N_EVT-1:0] evt_in;
  logic [N_EVT-1:0] evt_clr;
  logic             pending;

  always_comb begin
    evt_in            = '0;
    evt_in[EVT_READY] = hs_r && (wr_reset || flag_rise) && !wr_hs;
    // Line events wait until both sampled levels are real pin levels, not reset zeros.
    evt_in[EVT_EIR]   = warm_r[2] && !line_s.external_irq_input && line_prev_r.external_irq_input;
    evt_in[EVT_STI_A] = warm_r[2] && line_s.status_in_a != line_prev_r.status_in_a;
    evt_in[EVT_STI_B] = warm_r[2] && line_s.status_in_b != line_prev_r.status_in_b;
    evt_clr           = wr_reset ? '1 : (wr_evt ? w_data_r[N_EVT-1:0] : '0);
    evt_nxt           = (evt_r & ~evt_clr) | evt_in;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      evt_r <= '0;
    end else begin
      evt_r <= evt_nxt;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      mask_r <= '0;
    end else if (wr_mask) begin
      mask_r <= w_data_r[N_EVT-1:0];
    end
  end

  assign pending = |(evt_r & mask_r);
  assign irq     = pending && irq_dma_en_r[BIT_IRQ_EN];

  // AXI4-Lite read path; status is sampled at the edge that takes the address.
  logic        rvalid_r;
  logic [31:0] rdata_r;
  logic [1:0]  rresp_r;
  logic [31:0] rd_mux;
  logic        rd_ok;

  assign arready = !rvalid_r;
  assign rd_fire = arvalid && arready;
  assign rd_idx  = araddr[IDX_LSB +: 6];
  assign rvalid  = rvalid_r;
  assign rdata   = rdata_r;
  assign rresp   = rresp_r;

  always_comb begin
    rd_mux = '0;
    rd_ok  = 1'b1;
    unique case (rd_idx)
      IDX_IDENT:      rd_mux[7:0] = CARD_ID;
      IDX_IRQ_DMA: begin
        rd_mux[7:0]                      = irq_dma_en_r;
        rd_mux[BIT_IRQ_PEND]             = pending;
        rd_mux[BIT_PRIO_LO +: 2]         = prio_s;
      end
      IDX_LINE_CTL:   rd_mux = '0;
      IDX_DATA:       rd_mux[15:0] = din_s;
      IDX_READY:      rd_mux[0] = !hs_r;
      IDX_LINE_STATE: begin
        rd_mux[BIT_STI_A]   = !line_s.status_in_a;
        rd_mux[BIT_STI_B]   = !line_s.status_in_b;
        rd_mux[BIT_EIR_LOW] = !line_s.external_irq_input;
        rd_mux[BIT_PERIPHERAL_OK_INPUT_OK] = line_s.peripheral_ok_input;
      end
      IDX_EVT_STATUS: rd_mux[N_EVT-1:0] = evt_r;
      IDX_EVT_MASK:   rd_mux[N_EVT-1:0] = mask_r;
      IDX_IRQ_DMA_EN: rd_mux[7:0] = irq_dma_en_r;
      default:        rd_ok = 1'b0;
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid_r <= 1'b0;
      rdata_r  <= '0;
      rresp_r  <= RESP_OKAY;
    end else if (rd_fire) begin
      rvalid_r <= 1'b1;
      rdata_r  <= rd_mux;
      rresp_r  <= rd_ok ? RESP_OKAY : RESP_SLVERR;
    end else if (rready) begin
      rvalid_r <= 1'b0;
    end
  end

  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  a_ctl_low_drive: assert property (
    wr_ctl |=> (!control_out_a || !$past(w_data_r[BIT_CTL_A])) &&
      (!control_out_b || !$past(w_data_r[BIT_CTL_B])))
    else $error("control line a not low after setting its bit");
  a_ctl_high_drive: assert property (
    wr_ctl && !w_data_r[BIT_CTL_B] |=> control_out_b)
    else $error("control line b not high after clearing its bit");
  a_ctl_hold_level: assert property (
    !wr_ctl |=> $stable({control_out_a, control_out_b}))
    else $error("control lines moved without a control write");
  a_ctl_reset_keep: assert property (
    wr_reset && !wr_ctl |-> ##1 {control_out_a, control_out_b} ==
      $past({control_out_a, control_out_b}))
    else $error("interface reset changed control lines");
  a_line_state_read: assert property (
    rd_fire && rd_idx == IDX_LINE_STATE |=>
      rdata[7:0] == {4'h0, $past(line_s.peripheral_ok_input),
                     !$past(line_s.external_irq_input),
                     !$past(line_s.status_in_b), !$past(line_s.status_in_a)})
    else $error("line state read does not match line levels");
  a_reset_clears_hs: assert property (
    wr_reset |=> !handshake_request_out && irq_dma_en_r == 8'h00)
    else $error("interface reset did not clear handshake and enables");
  a_hs_set_line: assert property (
    wr_hs |=> handshake_request_out ##1 handshake_request_out || $past(flag_rise))
    else $error("handshake request not set");
  a_irq_dma_read: assert property (
    rd_fire && rd_idx == IDX_IRQ_DMA |=> rdata[7:6] ==
      {$past(irq_dma_en_r[BIT_IRQ_EN]), $past(pending)} && rdata[5:4] == $past(prio_s))
    else $error("interrupt and DMA state read wrong");
  a_din_word_read: assert property (
    rd_fire && rd_idx == IDX_DATA |=> rdata[15:0] == $past(din_s) && rdata[31:16] == 16'h0)
    else $error("input data word read wrong");
  a_dout_word_drive: assert property (
    wr_data && w_strb_r[1:0] == 2'b11 && !handshake_request_out |=>
      output_data_lines == $past(w_data_r[15:0]) && !io_direction_out &&
      !handshake_request_out)
    else $error("data word write misbehaved");
  a_ready_read: assert property (
    rd_fire && rd_idx == IDX_READY |=> rdata[0] == !$past(handshake_request_out))
    else $error("ready flag read wrong");
  a_din_dir_high: assert property (
    rd_fire && rd_idx == IDX_DATA && !wr_data && !wr_hs |=> io_direction_out && !$rose(hs_r))
    else $error("data read did not raise the direction line");
  a_power_up_high: assert property (
    $rose(aresetn) |-> control_out_a && control_out_b)
    else $error("control lines not high after reset");

endmodule // parallel_card_status_control_bank

// file: verification/periph_model.sv
`timescale 1ns/10ps
module periph_model
  import pcard_pkg::*;
(
  input  wire logic        aclk,
  input  wire logic        handshake_request_out,
  input  wire logic [3:0]  lvl,
  input  wire logic [15:0] din,
  input  wire logic [1:0]  prio,
  input  wire logic [3:0]  ack_dly,
  output      line_in_t    line_in,
  output      logic [15:0] input_data_lines,
  output      logic [1:0]  priority_switch
);
  logic [3:0] wait_r = 4'h0;
  logic       flag_r = 1'b0;

  // The flag answers a request after ack_dly plus one cycles and falls once the request is withdrawn.
  always_ff @(posedge aclk) begin
    if (!handshake_request_out) begin
      wait_r <= 4'h0;
    end else if (wait_r != 4'hf) begin
      wait_r <= wait_r + 4'h1;
    end
  end

  always_ff @(posedge aclk) begin
    flag_r <= handshake_request_out && (wait_r >= ack_dly);
  end

  assign line_in          = {lvl, flag_r};
  assign input_data_lines = din;
  assign priority_switch  = prio;
endmodule // periph_model

// file: verification/tb_top.sv
`timescale 1ns/10ps
module tb_top;
  import pcard_pkg::*;
  localparam logic [7:0] ID_VAL = 8'h3c;  // Arbitrary identity value.
  logic        aclk = 1'b0, aresetn = 1'b0;
  logic [7:0]  awaddr = 8'h00, araddr = 8'h00;
  logic [31:0] wdata = 32'h0, rdata;
  logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic        awready, wready, bvalid, arready, rvalid, ctl_a, ctl_b, hs, dir, irq;
  logic [1:0]  bresp, rresp, prio_l, prio = 2'b10;
  logic [15:0] dout, din_l, din = 16'h0000;
  logic [3:0]  lvl = 4'hf, ack_dly = 4'h0, wstrb = 4'hf;
  line_in_t    line_l;
  int          failures = 0, n_tests = 0;

  always #50 aclk = ~aclk;

  parallel_card_status_control_bank #(.ADDR_W(8), .CARD_ID(ID_VAL)) i_parallel_card_status_control_bank (
    .aclk(aclk), .aresetn(aresetn), .awaddr(awaddr), .awprot(3'h0), .awvalid(awvalid),
    .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready),
    .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr), .arprot(3'h0),
    .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid),
    .rready(rready), .line_in(line_l), .input_data_lines(din_l), .priority_switch(prio_l),
    .control_out_a(ctl_a), .control_out_b(ctl_b), .handshake_request_out(hs),
    .io_direction_out(dir), .output_data_lines(dout), .irq(irq));

  periph_model i_periph_model (
    .aclk(aclk), .handshake_request_out(hs), .lvl(lvl), .din(din), .prio(prio),
    .ack_dly(ack_dly), .line_in(line_l), .input_data_lines(din_l), .priority_switch(prio_l));

  task automatic complete_run;
    $display("Comparisons %0d, mismatches %0d", n_tests, failures);
    if (failures == 0 && n_tests > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_tests++;
    if (g !== e) begin
      failures++;
      $display("Error %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic cyc(input int k);
    repeat (k) @(posedge aclk);
  endtask

  // Address and data are offered together; each is dropped at the edge that takes it.
  task automatic wr(input logic [5:0] i, input logic [31:0] d, output logic [1:0] r);
    int n;
    r = 2'b11;
    @(posedge aclk);
    awaddr <= {i, 2'b00};
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    for (n = 0; n < 40; n++) begin
      @(posedge aclk);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
      if (bvalid && bready) begin
        r = bresp;
        bready <= 1'b0;
        break;
      end
    end
    if (n == 40) begin
      failures++;
      complete_run();
    end
  endtask

  task automatic rd(input logic [5:0] i, output logic [31:0] d, output logic [1:0] r);
    int n;
    @(posedge aclk);
    araddr <= {i, 2'b00};
    arvalid <= 1'b1;
    rready <= 1'b1;
    for (n = 0; n < 40; n++) begin
      @(posedge aclk);
      if (arvalid && arready) arvalid <= 1'b0;
      if (rvalid && rready) begin
        d = rdata;
        r = rresp;
        rready <= 1'b0;
        break;
      end
    end
    if (n == 40) begin
      failures++;
      complete_run();
    end
  endtask

  task automatic wok(input logic [5:0] i, input logic [31:0] d);
    logic [1:0] r;
    wr(i, d, r);
    chk("bresp", {30'h0, RESP_OKAY}, {30'h0, r});
  endtask

  task automatic rchk(input string nm, input logic [5:0] i, input logic [31:0] e);
    logic [31:0] d;
    logic [1:0]  r;
    rd(i, d, r);
    chk("rresp", {30'h0, RESP_OKAY}, {30'h0, r});
    chk(nm, e, d);
  endtask

  task automatic t_ctl;
    chk("ctl_reset", 32'h3, {30'h0, ctl_b, ctl_a});
    for (int v = 0; v < 4; v++) begin
      wok(IDX_LINE_CTL, 32'(v));
      cyc(3);
      chk("ctl_lines", 32'(~v & 3), {30'h0, ctl_b, ctl_a});
    end
    wok(IDX_DATA, 32'h1234);
    chk("ctl_hold", 32'h0, {30'h0, ctl_b, ctl_a});
    wok(IDX_IDENT, 32'h1);
    chk("ctl_after_reset", 32'h0, {30'h0, ctl_b, ctl_a});
    wok(IDX_LINE_CTL, 32'h2);
    chk("ctl_mixed", 32'h1, {30'h0, ctl_b, ctl_a});
  endtask

  // Every combination of the four lines, read back one after another.
  task automatic t_lines;
    logic [3:0] p;
    for (int v = 0; v < 16; v++) begin
      p = 4'(v);
      lvl <= p;
      cyc(4);
      rchk("line_state", IDX_LINE_STATE, {28'h0, p[1], !p[0], !p[2], !p[3]});
    end
  endtask

  task automatic t_data;
    din <= 16'h01ff;
    wok(IDX_DATA, 32'hfe01);
    chk("dout", 32'hfe01, {16'h0, dout});
    chk("dir_after_write", 32'h0, {31'h0, dir});
    chk("hs_after_write", 32'h0, {31'h0, hs});
    rchk("din", IDX_DATA, 32'h01ff);
    chk("dir_after_read", 32'h1, {31'h0, dir});
    chk("hs_after_read", 32'h0, {31'h0, hs});
    chk("dout_kept", 32'hfe01, {16'h0, dout});
    wstrb <= 4'h1;
    wok(IDX_DATA, 32'h00aa);
    chk("dout_low_lane", 32'hfeaa, {16'h0, dout});
    wstrb <= 4'hf;
  endtask

  task automatic t_hs;
    ack_dly <= 4'ha;
    wok(IDX_IRQ_DMA, 32'h0);
    chk("hs_zero_write", 32'h0, {31'h0, hs});
    wok(IDX_IRQ_DMA, 32'h80);
    chk("hs_set", 32'h1, {31'h0, hs});
    rchk("busy", IDX_READY, 32'h0);
    for (int n = 0; n < 30 && hs; n++) @(posedge aclk);
    chk("hs_acked", 32'h0, {31'h0, hs});
    rchk("ready", IDX_READY, 32'h1);
    ack_dly <= 4'hf;
    wok(IDX_IRQ_DMA, 32'h1);
    wok(IDX_IDENT, 32'h0);
    chk("hs_zero_reset", 32'h1, {31'h0, hs});
    wok(IDX_IDENT, 32'h40);
    chk("hs_reset", 32'h0, {31'h0, hs});
  endtask

  task automatic t_irq;
    wok(IDX_EVT_MASK, 32'h4);
    wok(IDX_IRQ_DMA_EN, 32'hff);
    wok(IDX_EVT_STATUS, 32'hf);
    chk("irq_idle", 32'h0, {31'h0, irq});
    rchk("irq_dma_idle", IDX_IRQ_DMA, 32'haf);
    lvl <= lvl ^ 4'h8;
    cyc(6);
    chk("irq_raised", 32'h1, {31'h0, irq});
    rchk("irq_dma_pend", IDX_IRQ_DMA, 32'hef);
    rchk("evt_status", IDX_EVT_STATUS, 32'h4);
    wok(IDX_EVT_MASK, 32'h0);
    chk("irq_masked", 32'h0, {31'h0, irq});
    wok(IDX_EVT_MASK, 32'h4);
    chk("irq_unmasked", 32'h1, {31'h0, irq});
    wok(IDX_EVT_STATUS, 32'h4);
    chk("irq_cleared", 32'h0, {31'h0, irq});
  endtask

  task automatic t_map;
    logic [31:0] d;
    logic [1:0]  r;
    wr(6'h06, 32'h1, r);
    chk("bresp_unmapped", {30'h0, RESP_SLVERR}, {30'h0, r});
    wr(IDX_READY, 32'h1, r);
    chk("bresp_readonly", {30'h0, RESP_SLVERR}, {30'h0, r});
    rd(6'h07, d, r);
    chk("rresp_unmapped", {30'h0, RESP_SLVERR}, {30'h0, r});
    chk("rdata_unmapped", 32'h0, d);
    rchk("ident", IDX_IDENT, {24'h0, ID_VAL});
    rchk("reserved", IDX_LINE_CTL, 32'h0);
  endtask

  initial begin
    cyc(2);
    aresetn <= 1'b1;
    cyc(3);
    t_ctl();
    t_lines();
    t_data();
    t_hs();
    t_irq();
    t_map();
    complete_run();
  end
endmodule // tb_top
